// [design/cif_defs.vh]
// register offsets, field positions, reset values and codes of the can irq/tx flag slice
`ifndef CIF_DEFS_VH
`define CIF_DEFS_VH

// register offsets on the plain register port
`define CIF_ADDR_W 4
`define CIF_OFS_RX_FLAG_VIEW 4'h4
`define CIF_OFS_RX_IRQ_ENABLE 4'h5
`define CIF_OFS_TX_FLAGS 4'h6

// field positions of rx_irq_enable
`define CIF_BIT_WAKE_IE 7
`define CIF_BIT_STATUS_CHANGE_IE 6
`define CIF_RX_SENS_HI 5
`define CIF_RX_SENS_LO 4
`define CIF_TX_SENS_HI 3
`define CIF_TX_SENS_LO 2
`define CIF_BIT_OVERRUN_IE 1
`define CIF_BIT_RX_FULL_IE 0

// field positions of the flag view register
`define CIF_BIT_WAKE_FLAG 7
`define CIF_BIT_STATUS_CHANGE_FLAG 6
`define CIF_BIT_OVERRUN_FLAG 1
`define CIF_BIT_RX_FULL_FLAG 0

// reset values
`define CIF_RST_RX_IRQ_ENABLE 8'h00
`define CIF_RST_TX_EMPTY 1'b1
`define CIF_RST_STATUS 2'h0

// error state codes and thresholds
`define CIF_ST_OK 2'h0
`define CIF_ST_WARN 2'h1
`define CIF_ST_ERR 2'h2
`define CIF_ST_BUS_OFF 2'h3
`define CIF_WARN_LIMIT 8'd96
`define CIF_ERR_LIMIT 8'd127
`define CIF_BUS_OFF_LIMIT 9'd255

// sensitivity selections
`define CIF_SENS_NONE 2'h0
`define CIF_SENS_BUS_OFF 2'h1
`define CIF_SENS_ERR 2'h2
`define CIF_SENS_ALL 2'h3

`endif

// [design/cif_status_track.v]
// receiver/transmitter error state tracking with blocking status change flag
`timescale 1ns/100ps
`include "cif_defs.vh"

module cif_status_track (
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] rx_err_cnt,
    input wire [8:0] tx_err_cnt,
    input wire [1:0] rx_state_sensitivity,
    input wire [1:0] tx_state_sensitivity,
    input wire flag_clear,
    output reg [1:0] rx_status_q,
    output reg [1:0] tx_status_q,
    output reg status_change_flag_q
);

// --------------------------------------------------------------
// state decode
// --------------------------------------------------------------

// does a change from old to new count at this sensitivity
function sens_hit;
    input [1:0] sel;
    input [1:0] old_st;
    input [1:0] new_st;
    begin
        case (sel)
            `CIF_SENS_NONE: sens_hit = 1'b0;
            `CIF_SENS_BUS_OFF: sens_hit = (old_st == `CIF_ST_BUS_OFF) != (new_st == `CIF_ST_BUS_OFF);
            `CIF_SENS_ERR: sens_hit = (old_st >= `CIF_ST_ERR) != (new_st >= `CIF_ST_ERR);
            default: sens_hit = (old_st != new_st);
        endcase
    end
endfunction

reg [1:0] rx_now; // actual receiver state
reg [1:0] tx_now; // actual transmitter state
reg hit; // a qualifying change happened

always @* begin
    if (tx_err_cnt > `CIF_BUS_OFF_LIMIT) begin
        rx_now = `CIF_ST_BUS_OFF;
        tx_now = `CIF_ST_BUS_OFF;
    end else begin
        rx_now = (rx_err_cnt > `CIF_ERR_LIMIT) ? `CIF_ST_ERR :
                 (rx_err_cnt > `CIF_WARN_LIMIT) ? `CIF_ST_WARN : `CIF_ST_OK;
        tx_now = (tx_err_cnt > {1'b0, `CIF_ERR_LIMIT}) ? `CIF_ST_ERR :
                 (tx_err_cnt > {1'b0, `CIF_WARN_LIMIT}) ? `CIF_ST_WARN : `CIF_ST_OK;
        // leaving bus-off skips receiver to ok
        if (tx_status_q == `CIF_ST_BUS_OFF)
            rx_now = `CIF_ST_OK;
    end
    hit = sens_hit(rx_state_sensitivity, rx_status_q, rx_now) |
          sens_hit(tx_state_sensitivity, tx_status_q, tx_now);
end

// --------------------------------------------------------------
// status registers and flag
// --------------------------------------------------------------

// status frozen while flag pending; clear acts only while pending, no new set until cleared
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        rx_status_q <= `CIF_RST_STATUS;
        tx_status_q <= `CIF_RST_STATUS;
        status_change_flag_q <= 1'b0;
    end else if (!status_change_flag_q) begin
        rx_status_q <= rx_now;
        tx_status_q <= tx_now;
        status_change_flag_q <= hit;
    end else if (flag_clear) begin
        status_change_flag_q <= 1'b0;
    end
end

endmodule

// [design/cif_tx_slot.v]
// one transmit buffer empty flag with its abort side effects
`timescale 1ns/100ps
`include "cif_defs.vh"

module cif_tx_slot (
    input wire sys_clk,
    input wire rst_n,
    input wire init_hold,
    input wire clear_req,
    input wire tx_done,
    input wire abort_grant,
    input wire scheduled,
    output reg empty_q,
    output reg abort_req_clr_q,
    output reg abort_ack_clr_q,
    output reg access_block_q
);

wire set_ev = tx_done | abort_grant; // flag set event

// set on success or granted abort; set wins over clear
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        empty_q <= `CIF_RST_TX_EMPTY;
        abort_req_clr_q <= 1'b0;
        abort_ack_clr_q <= 1'b0;
        access_block_q <= 1'b0;
    end else begin
        // held at reset value in init mode
        if (init_hold)
            empty_q <= `CIF_RST_TX_EMPTY;
        else if (set_ev)
            empty_q <= 1'b1;
        else if (clear_req)
            empty_q <= 1'b0;
        abort_req_clr_q <= set_ev & ~init_hold;
        abort_ack_clr_q <= clear_req & ~set_ev & ~init_hold & empty_q;
        access_block_q <= ~empty_q & scheduled;
    end
end

endmodule

// [design/cif_top.v]
// can receiver irq enables, status tracking and transmit buffer empty flags
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "cif_defs.vh"

// Operation
// - enables held at reset in init mode
// - enable writes only outside init mode
// - sensitivity fields survive init mode
// - bit 7 gates wake-up request
// - bit 6 gates status change error request
// - receiver sensitivity decode in bits 5:4
// - transmitter sensitivity decode in bits 3:2
// - status shows actual state when not pending
// - bit 1 gates overrun error request
// - bit 0 gates receive full request
// - write one clears empty flag
// - tx flags held at reset in init
// - software clears, device sets after sending
// - granted abort also sets empty flag
// - tx request while enabled flag set
// - clearing flag clears abort acknowledge
// - setting flag clears abort request
// - listen mode: no clear, no start
// - scheduled buffer access blocked
// - tx bus-off exit forces receiver ok
// - receiver status coding by error counts
// - status change flag blocks status updates
module cif_top (
    input wire sys_clk,
    input wire rst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    // mode inputs
    input wire init_request,
    input wire init_acknowledge,
    input wire listen_mode,
    // receiver side flags kept elsewhere
    input wire wake_flag,
    input wire overrun_flag,
    input wire rx_full_flag,
    // error counters
    input wire [7:0] rx_err_cnt,
    input wire [8:0] tx_err_cnt,
    // transmit side
    input wire [2:0] tx_irq_enable,
    input wire [2:0] tx_done,
    input wire [2:0] abort_grant,
    input wire [2:0] tx_scheduled,
    output reg [2:0] tx_buffer_empty_q,
    output reg [2:0] abort_req_clr_q,
    output reg [2:0] abort_ack_clr_q,
    output reg [2:0] buf_access_block_q,
    output reg tx_start_allow_q,
    // status
    output reg [1:0] rx_status_q,
    output reg [1:0] tx_status_q,
    output reg status_change_flag_q,
    // interrupt requests
    output reg wake_irq_q,
    output reg err_irq_q,
    output reg rx_irq_q,
    output reg tx_irq_q
);

// --------------------------------------------------------------
// mode decode
// --------------------------------------------------------------

// both handshake bits high: initialization mode
wire init_hold = init_request & init_acknowledge;

// both low: normal mode, registers writable
wire init_free = ~init_request & ~init_acknowledge;

// write strobes per register
wire wr_rier = reg_wr & (reg_addr == `CIF_OFS_RX_IRQ_ENABLE);
wire wr_tflg = reg_wr & (reg_addr == `CIF_OFS_TX_FLAGS);
wire wr_view = reg_wr & (reg_addr == `CIF_OFS_RX_FLAG_VIEW);

// --------------------------------------------------------------
// receiver interrupt enable register
// --------------------------------------------------------------

reg wake_ie_q; // wake-up interrupt enable
reg status_change_ie_q; // status change interrupt enable
reg overrun_ie_q; // overrun interrupt enable
reg rx_full_ie_q; // receive full interrupt enable
reg [1:0] rx_sens_q; // receiver state sensitivity
reg [1:0] tx_sens_q; // transmitter state sensitivity

// plain enable bits
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        wake_ie_q <= 1'b0;
        status_change_ie_q <= 1'b0;
        overrun_ie_q <= 1'b0;
        rx_full_ie_q <= 1'b0;
    end else if (init_hold) begin
        wake_ie_q <= 1'b0;
        status_change_ie_q <= 1'b0;
        overrun_ie_q <= 1'b0;
        rx_full_ie_q <= 1'b0;
    end else if (wr_rier && init_free) begin
        wake_ie_q <= reg_wdata[`CIF_BIT_WAKE_IE];
        status_change_ie_q <= reg_wdata[`CIF_BIT_STATUS_CHANGE_IE];
        overrun_ie_q <= reg_wdata[`CIF_BIT_OVERRUN_IE];
        rx_full_ie_q <= reg_wdata[`CIF_BIT_RX_FULL_IE];
    end
end

// sensitivity fields
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        rx_sens_q <= 2'h0;
        tx_sens_q <= 2'h0;
    end else if (wr_rier && init_free) begin
        rx_sens_q <= reg_wdata[`CIF_RX_SENS_HI:`CIF_RX_SENS_LO];
        tx_sens_q <= reg_wdata[`CIF_TX_SENS_HI:`CIF_TX_SENS_LO];
    end
end

// --------------------------------------------------------------
// status tracking
// --------------------------------------------------------------

wire [1:0] rx_status_w; // tracked receiver state
wire [1:0] tx_status_w; // tracked transmitter state
wire sc_flag_w; // status change flag

// write one to bit 6 of the flag view clears the status change flag
wire sc_clear = wr_view & init_free & reg_wdata[`CIF_BIT_STATUS_CHANGE_FLAG];

// state tracker with blocking flag
cif_status_track u_status (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rx_err_cnt(rx_err_cnt),
    .tx_err_cnt(tx_err_cnt),
    .rx_state_sensitivity(rx_sens_q),
    .tx_state_sensitivity(tx_sens_q),
    .flag_clear(sc_clear),
    .rx_status_q(rx_status_w),
    .tx_status_q(tx_status_w),
    .status_change_flag_q(sc_flag_w)
);

// --------------------------------------------------------------
// transmit buffer empty flags
// --------------------------------------------------------------

wire [2:0] empty_w; // per buffer empty flag
wire [2:0] req_clr_w; // per buffer abort request clear
wire [2:0] ack_clr_w; // per buffer abort acknowledge clear
wire [2:0] block_w; // per buffer access block
wire [2:0] clear_req; // qualified write one clear

// write one clears outside init and listen
assign clear_req = {3{wr_tflg & init_free & ~listen_mode}} & reg_wdata[2:0];

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_slot
        // one slot per transmit buffer
        cif_tx_slot u_slot (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .init_hold(init_hold),
            .clear_req(clear_req[gi]),
            .tx_done(tx_done[gi]),
            .abort_grant(abort_grant[gi]),
            .scheduled(tx_scheduled[gi]),
            .empty_q(empty_w[gi]),
            .abort_req_clr_q(req_clr_w[gi]),
            .abort_ack_clr_q(ack_clr_w[gi]),
            .access_block_q(block_w[gi])
        );
    end
endgenerate

// --------------------------------------------------------------
// output registers
// --------------------------------------------------------------

// mirror submodule state onto top outputs
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        tx_buffer_empty_q <= {3{`CIF_RST_TX_EMPTY}};
        abort_req_clr_q <= 3'h0;
        abort_ack_clr_q <= 3'h0;
        buf_access_block_q <= 3'h0;
        rx_status_q <= `CIF_RST_STATUS;
        tx_status_q <= `CIF_RST_STATUS;
        status_change_flag_q <= 1'b0;
        tx_start_allow_q <= 1'b0;
    end else begin
        tx_buffer_empty_q <= empty_w;
        abort_req_clr_q <= req_clr_w;
        abort_ack_clr_q <= ack_clr_w;
        buf_access_block_q <= block_w;
        rx_status_q <= rx_status_w;
        tx_status_q <= tx_status_w;
        status_change_flag_q <= sc_flag_w;
        // no transmission start in listen mode
        tx_start_allow_q <= ~listen_mode & ~init_hold;
    end
end

// --------------------------------------------------------------
// interrupt requests
// --------------------------------------------------------------

// each request is an or of one or more flag and enable ands
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        wake_irq_q <= 1'b0;
        err_irq_q <= 1'b0;
        rx_irq_q <= 1'b0;
        tx_irq_q <= 1'b0;
    end else begin
        wake_irq_q <= wake_flag & wake_ie_q;
        // error request from status change or overrun
        err_irq_q <= (sc_flag_w & status_change_ie_q) | (overrun_flag & overrun_ie_q);
        rx_irq_q <= rx_full_flag & rx_full_ie_q;
        // pending while any enabled empty flag set
        tx_irq_q <= |(empty_w & tx_irq_enable);
    end
end

// --------------------------------------------------------------
// read data
// --------------------------------------------------------------

reg [7:0] rd_mux; // combinational read selection

// select register contents by address
always @* begin
    rd_mux = 8'h00;
    case (reg_addr)
        `CIF_OFS_RX_FLAG_VIEW: begin
            // flag view with tracked status
            rd_mux = {wake_flag, sc_flag_w, rx_status_w, tx_status_w,
                      overrun_flag, rx_full_flag};
        end
        `CIF_OFS_RX_IRQ_ENABLE: begin
            // enables and sensitivity fields
            rd_mux = {wake_ie_q, status_change_ie_q, rx_sens_q, tx_sens_q,
                      overrun_ie_q, rx_full_ie_q};
        end
        `CIF_OFS_TX_FLAGS: begin
            // empty flags in the low bits
            rd_mux = {5'h00, empty_w};
        end
        default: begin
            // unmapped reads as zero
            rd_mux = 8'h00;
        end
    endcase
end

// read data stand in the cycle after the strobe only
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
        reg_rdata_q <= 8'h00;
    else if (reg_rd)
        reg_rdata_q <= rd_mux;
    else
        reg_rdata_q <= 8'h00;
end

endmodule

// [testbench/cif_checker.sv]
// port assertions for the can irq/tx flag slice
`timescale 1ns/100ps
module cif_checker (
    input wire sys_clk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    input wire init_request,
    input wire init_acknowledge,
    input wire listen_mode,
    input wire [2:0] tx_irq_enable,
    input wire [2:0] tx_done,
    input wire [2:0] abort_grant,
    input wire [2:0] tx_buffer_empty_q,
    input wire [2:0] abort_req_clr_q,
    input wire [2:0] abort_ack_clr_q,
    input wire tx_start_allow_q,
    input wire [1:0] rx_status_q,
    input wire [1:0] tx_status_q,
    input wire status_change_flag_q,
    input wire tx_irq_q
);
    wire init_w; // both init bits set
    assign init_w = init_request & init_acknowledge;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ------
    // register port and transmit flags
    // ------
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
        else $error("read data outside read cycle");
    a_done_sets: assert property (tx_done[0] && !init_w |-> ##2
        tx_buffer_empty_q[0] && abort_req_clr_q[0]) else $error("done did not set flag");
    a_abort_sets: assert property (abort_grant[1] && !init_w |-> ##2
        tx_buffer_empty_q[1] && abort_req_clr_q[1]) else $error("abort did not set flag");
    a_clear_ack: assert property ($fell(tx_buffer_empty_q[0]) |-> abort_ack_clr_q[0])
        else $error("no ack clear on flag clear");
    a_clear_cause: assert property ($fell(tx_buffer_empty_q[2]) |-> $past(reg_wr, 2)
        && !$past(listen_mode, 2) && !$past(init_request, 2)) else $error("bad flag clear");
    a_init_hold: assert property (init_w [*3] |-> tx_buffer_empty_q == 3'h7)
        else $error("flags not held in init");
    a_listen_stop: assert property (listen_mode [*2] |-> !tx_start_allow_q)
        else $error("start allowed in listen");
    a_tx_irq: assert property ($stable(tx_irq_enable) |->
        tx_irq_q == |(tx_buffer_empty_q & tx_irq_enable)) else $error("tx request wrong");
    // ------
    // status tracking
    // ------
    a_status_frozen: assert property (status_change_flag_q && $past(status_change_flag_q)
        |-> $stable(rx_status_q) && $stable(tx_status_q)) else $error("status moved");
endmodule
bind cif_top cif_checker u_chk (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_rdata_q,
    .init_request, .init_acknowledge, .listen_mode, .tx_irq_enable, .tx_done, .abort_grant,
    .tx_buffer_empty_q, .abort_req_clr_q, .abort_ack_clr_q, .tx_start_allow_q,
    .rx_status_q, .tx_status_q, .status_change_flag_q, .tx_irq_q);

// [testbench/cif_engine_model.sv]
// behavioural transmit engine answering the transmit buffers
`timescale 1ns/100ps
module cif_engine_model (
    input wire sys_clk,
    input wire rst_n,
    input wire [2:0] go,
    input wire [2:0] abt,
    input wire slow,
    input wire tx_start_allow_q,
    input wire [2:0] tx_buffer_empty_q,
    output reg [2:0] tx_done,
    output reg [2:0] abort_grant,
    output wire [2:0] tx_scheduled
);
    wire [2:0] send_w; // completions that may start now
    reg [2:0] done_s_q; // delayed completion for slow answers
    reg [2:0] abt_s_q; // delayed abort grant
    // ------
    // queue and answers
    // ------
    // cleared buffer queued
    assign tx_scheduled = ~tx_buffer_empty_q;
    assign send_w = go & tx_scheduled & {3{tx_start_allow_q}};
    // answer after one cycle, or two when slow
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_s_q <= 3'h0;
            abt_s_q <= 3'h0;
            tx_done <= 3'h0;
            abort_grant <= 3'h0;
        end else begin
            done_s_q <= send_w;
            abt_s_q <= abt & tx_scheduled;
            tx_done <= slow ? done_s_q : send_w;
            abort_grant <= slow ? abt_s_q : (abt & tx_scheduled);
        end
    end
endmodule

// [testbench/tb.sv]
// self-checking bench for the can irq/tx flag slice
`timescale 1ns/100ps
`include "cif_defs.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
$display("BAD t=%0t got %h exp %h", $time, a, e); end end
module tb;
    // ------
    // signals
    // ------
    reg sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    reg init_request = 1'b0, init_acknowledge = 1'b0, listen_mode = 1'b0;
    reg wake_flag = 1'b0, overrun_flag = 1'b0, rx_full_flag = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00, rx_err_cnt = 8'h00, rdv;
    reg [8:0] tx_err_cnt = 9'h000;
    reg [2:0] tx_irq_enable = 3'h0, go = 3'h0, abt = 3'h0;
    wire [7:0] reg_rdata_q;
    wire [2:0] tx_done, abort_grant, tx_scheduled, tx_buffer_empty_q;
    wire [2:0] abort_req_clr_q, abort_ack_clr_q, buf_access_block_q;
    wire [1:0] rx_status_q, tx_status_q;
    wire tx_start_allow_q, status_change_flag_q, wake_irq_q, err_irq_q, rx_irq_q, tx_irq_q;
    integer mismatches = 0, comparisons = 0, cycles = 0, i;
    localparam [39:0] MASKS = 40'h80_40_02_01_00; // enable patterns tried
    cif_top dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .init_request, .init_acknowledge, .listen_mode, .wake_flag, .overrun_flag,
        .rx_full_flag, .rx_err_cnt, .tx_err_cnt, .tx_irq_enable, .tx_done, .abort_grant,
        .tx_scheduled, .tx_buffer_empty_q, .abort_req_clr_q, .abort_ack_clr_q,
        .buf_access_block_q, .tx_start_allow_q, .rx_status_q, .tx_status_q,
        .status_change_flag_q, .wake_irq_q, .err_irq_q, .rx_irq_q, .tx_irq_q);
    cif_engine_model eng (.sys_clk, .rst_n, .go, .abt, .slow, .tx_start_allow_q,
        .tx_buffer_empty_q, .tx_done, .abort_grant, .tx_scheduled);
    // 40 mhz clock
    always #12.5 sys_clk = ~sys_clk;
    // ------
    // access tasks
    // ------
    task cyc(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    task wr(input [3:0] a, input [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands in the cycle after the strobe
    task rd(input [3:0] a, output [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    // one-cycle request to the engine model
    task kick(input [2:0] g, input [2:0] a, input s);
        @(posedge sys_clk);
        go <= g;
        abt <= a;
        slow <= s;
        @(posedge sys_clk);
        go <= 3'h0;
        abt <= 3'h0;
    endtask
    task set_init(input v);
        @(posedge sys_clk);
        init_request <= v;
        init_acknowledge <= v;
    endtask
    // sensitivity, optional flag clear, counters, then status check
    task st(input [7:0] s, input [7:0] r, input [8:0] t, input c, input [5:0] e);
        wr(`CIF_OFS_RX_IRQ_ENABLE, 8'h40 | s);
        if (c) wr(`CIF_OFS_RX_FLAG_VIEW, 8'h40);
        @(posedge sys_clk);
        rx_err_cnt <= r;
        tx_err_cnt <= t;
        cyc(5);
        `CHK({rx_status_q, tx_status_q, status_change_flag_q, err_irq_q}, e)
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            finish_test;
        end
    end
    // ------
    // test sequence
    // ------
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(2);
        rd(`CIF_OFS_RX_IRQ_ENABLE, rdv);
        `CHK(rdv, `CIF_RST_RX_IRQ_ENABLE)
        rd(`CIF_OFS_TX_FLAGS, rdv);
        `CHK(rdv[2:0], 3'h7)
        rd(4'hf, rdv);
        `CHK(rdv, 8'h00)
        wr(`CIF_OFS_RX_IRQ_ENABLE, 8'hff);
        rd(`CIF_OFS_RX_IRQ_ENABLE, rdv);
        `CHK(rdv, 8'hff)
        set_init(1'b1);
        cyc(3);
        rd(`CIF_OFS_RX_IRQ_ENABLE, rdv);
        `CHK(rdv, 8'h3c)
        wr(`CIF_OFS_RX_IRQ_ENABLE, 8'h00);
        rd(`CIF_OFS_RX_IRQ_ENABLE, rdv);
        `CHK(rdv, 8'h3c)
        set_init(1'b0);
        $display("test enables done");
        wake_flag <= 1'b1;
        overrun_flag <= 1'b1;
        rx_full_flag <= 1'b1;
        for (i = 0; i < 5; i++) begin
            wr(`CIF_OFS_RX_IRQ_ENABLE, MASKS[39-8*i -: 8]);
            cyc(4);
            `CHK({wake_irq_q, err_irq_q, rx_irq_q}, {MASKS[39-8*i], MASKS[33-8*i], MASKS[32-8*i]})
        end
        overrun_flag <= 1'b0;
        $display("test requests done");
        st(8'h10, 8'h64, 9'h000, 1'b0, 6'h10);
        st(8'h20, 8'h82, 9'h000, 1'b0, 6'h23);
        st(8'h20, 8'h00, 9'h000, 1'b0, 6'h23);
        st(8'h00, 8'h00, 9'h000, 1'b1, 6'h00);
        st(8'h0c, 8'h00, 9'h064, 1'b0, 6'h07);
        st(8'h04, 8'h00, 9'h12c, 1'b1, 6'h3f);
        st(8'h00, 8'h00, 9'h000, 1'b1, 6'h00);
        st(8'h30, 8'h60, 9'h000, 1'b0, 6'h00);
        st(8'h30, 8'h61, 9'h000, 1'b0, 6'h13);
        st(8'h00, 8'h00, 9'h000, 1'b1, 6'h00);
        $display("test status done");
        wr(`CIF_OFS_TX_FLAGS, 8'h00);
        cyc(3);
        `CHK(tx_buffer_empty_q, 3'h7)
        wr(`CIF_OFS_TX_FLAGS, 8'h01);
        // access block needs one more edge through the queue model
        cyc(4);
        `CHK({tx_buffer_empty_q, buf_access_block_q}, 6'h31)
        kick(3'h1, 3'h0, 1'b0);
        cyc(4);
        `CHK({tx_buffer_empty_q, buf_access_block_q}, 6'h38)
        wr(`CIF_OFS_TX_FLAGS, 8'h02);
        kick(3'h0, 3'h2, 1'b1);
        cyc(5);
        `CHK(tx_buffer_empty_q, 3'h7)
        tx_irq_enable <= 3'h4;
        wr(`CIF_OFS_TX_FLAGS, 8'h04);
        cyc(3);
        `CHK(tx_irq_q, 1'b0)
        kick(3'h4, 3'h0, 1'b1);
        cyc(5);
        `CHK(tx_irq_q, 1'b1)
        listen_mode <= 1'b1;
        wr(`CIF_OFS_TX_FLAGS, 8'h07);
        cyc(3);
        `CHK({tx_buffer_empty_q, tx_start_allow_q}, 4'he)
        listen_mode <= 1'b0;
        wr(`CIF_OFS_TX_FLAGS, 8'h07);
        rd(`CIF_OFS_TX_FLAGS, rdv);
        `CHK(rdv[2:0], 3'h0)
        set_init(1'b1);
        cyc(4);
        `CHK(tx_buffer_empty_q, 3'h7)
        wr(`CIF_OFS_TX_FLAGS, 8'h07);
        cyc(3);
        `CHK(tx_buffer_empty_q, 3'h7)
        set_init(1'b0);
        $display("test tx flags done");
        finish_test;
    end
endmodule
